// File: wave_shaping_defs.svh
`ifndef WAVE_SHAPING_DEFS_SVH
`define WAVE_SHAPING_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CLAMP_RELEASE 8'h34
`define ADDR_MOD_SWITCH_RES 8'h35
`define ADDR_STOP_RAIL_RET 8'h36
`define ADDR_CLAMP_CONNECT 8'h37
`define ADDR_RES_RETURN 8'h38
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define REG_RESET 8'h00
`define FIELD_HI_MSB 7
`define FIELD_HI_LSB 4
`define FIELD_LO_MSB 3
`define FIELD_LO_LSB 0
// ----------------------------------------
// Timing counts, in carrier periods
// ----------------------------------------
`define COUNT_MAX 5'h1f
`define RECOVER_COUNT 5'h10
`endif

// File: wave_shaping_pkg.sv
package wave_shaping_pkg;
  // Phase of the modulation pulse that the counter is timing
  typedef enum logic [2:0] {
    IDLE_ST = 3'b001,
    PULSE_ST = 3'b010,
    AFTER_ST = 3'b100
  } wave_state_type;

  // Driver control bundle sent to the analog driver
  typedef struct packed {
    logic clamp_released;
    logic on_mod_rail;
    logic mod_resistance;
    logic driving;
  } driver_ctrl_type;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage : wave_shaping_pkg

// File: wave_shaping_timing_regs.sv
// Design decision made here: the address-and-strobe port.
`include "wave_shaping_defs.svh"

module wave_shaping_timing_regs
  import wave_shaping_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire reg_req_type req, // Register bus request
  output logic [7:0] rdata, // Read data, one cycle after read
  input wire logic carrier_tick, // One pulse per carrier period
  input wire logic mod_pulse, // High during a modulation pulse
  output driver_ctrl_type drv // Driver controls
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [3:0] clamp_release_time; // Clamp release count
  logic [3:0] mod_rail_switch_time; // Modulation rail switch count
  logic [3:0] mod_resistance_time; // Modulation resistance count
  logic [3:0] drive_stop_time; // Drive stop count
  logic [3:0] rf_rail_return_time; // RF rail return count
  logic [3:0] clamp_connect_time; // Clamp reconnect count
  logic [3:0] drive_resistance_time; // Driving resistance count

  // Register writes; reserved nibbles are not stored and read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clamp_release_time <= 4'h0;
      mod_rail_switch_time <= 4'h0;
      mod_resistance_time <= 4'h0;
      drive_stop_time <= 4'h0;
      rf_rail_return_time <= 4'h0;
      clamp_connect_time <= 4'h0;
      drive_resistance_time <= 4'h0;
    end else if (req.wr) begin
      case (req.addr)
        `ADDR_CLAMP_RELEASE: begin
          clamp_release_time <= req.wdata[`FIELD_LO_MSB:`FIELD_LO_LSB];
        end
        `ADDR_MOD_SWITCH_RES: begin
          mod_rail_switch_time <= req.wdata[`FIELD_HI_MSB:`FIELD_HI_LSB];
          mod_resistance_time <= req.wdata[`FIELD_LO_MSB:`FIELD_LO_LSB];
        end
        `ADDR_STOP_RAIL_RET: begin
          drive_stop_time <= req.wdata[`FIELD_HI_MSB:`FIELD_HI_LSB];
          rf_rail_return_time <= req.wdata[`FIELD_LO_MSB:`FIELD_LO_LSB];
        end
        `ADDR_CLAMP_CONNECT: begin
          clamp_connect_time <= req.wdata[`FIELD_LO_MSB:`FIELD_LO_LSB];
        end
        `ADDR_RES_RETURN: begin
          drive_resistance_time <= req.wdata[`FIELD_HI_MSB:`FIELD_HI_LSB];
        end
        default: begin
          // Unmapped address: write ignored
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= `REG_RESET;
    end else if (req.rd) begin
      case (req.addr)
        `ADDR_CLAMP_RELEASE: rdata <= {4'h0, clamp_release_time};
        `ADDR_MOD_SWITCH_RES: rdata <= {mod_rail_switch_time, mod_resistance_time};
        `ADDR_STOP_RAIL_RET: rdata <= {drive_stop_time, rf_rail_return_time};
        `ADDR_CLAMP_CONNECT: rdata <= {4'h0, clamp_connect_time};
        `ADDR_RES_RETURN: rdata <= {drive_resistance_time, 4'h0};
        default: rdata <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Pulse phase tracking
  // ----------------------------------------
  wave_state_type state; // Current phase
  logic [4:0] count; // Carrier periods since the phase edge
  logic pulse_prev; // Previous pulse level for edge detection

  // Saturating increment; 5 bits so a setting of 15 is always reached
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == `COUNT_MAX) ? v : 5'(v + 5'h01);
  endfunction : sat_inc

  // Phase machine; a pulse edge restarts the count at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IDLE_ST;
      count <= 5'h00;
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= mod_pulse;
      case (state)
        IDLE_ST: begin
          if (mod_pulse && !pulse_prev) begin
            state <= PULSE_ST;
            count <= 5'h00;
          end
        end
        PULSE_ST: begin
          if (!mod_pulse) begin
            state <= AFTER_ST;
            count <= 5'h00;
          end else if (carrier_tick) begin
            count <= sat_inc(count);
          end
        end
        AFTER_ST: begin
          if (mod_pulse && !pulse_prev) begin
            state <= PULSE_ST; // New pulse before recovery finished
            count <= 5'h00;
          end else if (carrier_tick) begin
            count <= sat_inc(count);
            if (count == `RECOVER_COUNT) begin
              state <= IDLE_ST; // All second-phase times have passed
            end
          end
        end
        default: begin
          state <= IDLE_ST;
          count <= 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Driver controls
  // ----------------------------------------
  // First phase asserts at a count; second phase undoes at a count, except driving, which resumes at once.
  // Controls stay in their idle level while the phase machine is in IDLE_ST.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv <= '{clamp_released: 1'b0, on_mod_rail: 1'b0, mod_resistance: 1'b0,
               driving: 1'b1};
    end else begin
      case (state)
        PULSE_ST: begin
          if (count >= {1'b0, clamp_release_time}) drv.clamp_released <= 1'b1;
          if (count >= {1'b0, mod_rail_switch_time}) drv.on_mod_rail <= 1'b1;
          if (count >= {1'b0, mod_resistance_time}) drv.mod_resistance <= 1'b1;
          if (count >= {1'b0, drive_stop_time}) drv.driving <= 1'b0;
        end
        AFTER_ST: begin
          if (count >= {1'b0, rf_rail_return_time}) drv.on_mod_rail <= 1'b0;
          if (count >= {1'b0, clamp_connect_time}) drv.clamp_released <= 1'b0;
          if (count >= {1'b0, drive_resistance_time}) drv.mod_resistance <= 1'b0;
          drv.driving <= 1'b1; // Drive resumes once the pulse has ended
        end
        default: begin
          drv <= '{clamp_released: 1'b0, on_mod_rail: 1'b0, mod_resistance: 1'b0,
                   driving: 1'b1};
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_clamp_release: assert property (@(posedge clk) disable iff (!rst_b)
    (state == PULSE_ST && count >= {1'b0, clamp_release_time}) |=> drv.clamp_released)
    else $error("clamp not released at its count");
  chk_mod_rail: assert property (@(posedge clk) disable iff (!rst_b)
    (state == PULSE_ST && count >= {1'b0, mod_rail_switch_time}) |=> drv.on_mod_rail)
    else $error("modulation rail switch late");
  chk_mod_res: assert property (@(posedge clk) disable iff (!rst_b)
    (state == PULSE_ST && count >= {1'b0, mod_resistance_time}) |=> drv.mod_resistance)
    else $error("modulation resistance late");
  chk_drive_stop: assert property (@(posedge clk) disable iff (!rst_b)
    (state == PULSE_ST && count >= {1'b0, drive_stop_time}) |=> !drv.driving)
    else $error("driver did not stop");
  chk_rail_return: assert property (@(posedge clk) disable iff (!rst_b)
    (state == AFTER_ST && count >= {1'b0, rf_rail_return_time}) |=> !drv.on_mod_rail)
    else $error("rail not returned");
  chk_clamp_connect: assert property (@(posedge clk) disable iff (!rst_b)
    (state == AFTER_ST && count >= {1'b0, clamp_connect_time}) |=> !drv.clamp_released)
    else $error("clamp not reconnected");
  chk_res_return: assert property (@(posedge clk) disable iff (!rst_b)
    (state == AFTER_ST && count >= {1'b0, drive_resistance_time}) |=> !drv.mod_resistance)
    else $error("resistance not returned");
  chk_pulse_start: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IDLE_ST && mod_pulse && !pulse_prev) |=> (state == PULSE_ST && count == 5'h00))
    else $error("pulse start not counted from zero");
  chk_idle_level: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state == IDLE_ST) |=> (drv.driving && !drv.on_mod_rail))
    else $error("idle driver level wrong");
  // Recovery ends two ticks after the last second-phase count can be due
  chk_recover_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (state == AFTER_ST && !(mod_pulse && !pulse_prev) && carrier_tick
     && count == `RECOVER_COUNT) |=> state == IDLE_ST)
    else $error("recovery did not end");
  chk_drive_resume: assert property (@(posedge clk) disable iff (!rst_b)
    state == AFTER_ST |=> drv.driving)
    else $error("drive not resumed after pulse");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd |=> rdata == 8'h00)
    else $error("read data stood too long");

  cov_pulse: cover property (@(posedge clk) disable iff (!rst_b) state == PULSE_ST);
  cov_after: cover property (@(posedge clk) disable iff (!rst_b) state == AFTER_ST);
  cov_full: cover property (@(posedge clk) disable iff (!rst_b)
    state == AFTER_ST ##[1:200] state == IDLE_ST);
  cov_stop: cover property (@(posedge clk) disable iff (!rst_b) !drv.driving);

endmodule : wave_shaping_timing_regs

// File: tb_wave_shaping_timing_regs.sv
`include "wave_shaping_defs.svh"

module tb_wave_shaping_timing_regs
  import wave_shaping_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0; // 100 MHz clock
  logic rst_b = 1'b0; // Reset held from time zero
  reg_req_type req = '0; // Register bus request
  logic [7:0] rdata; // Read data from the block
  logic carrier_tick = 1'b0; // Carrier period pulse
  logic mod_pulse = 1'b0; // Modulation pulse level
  driver_ctrl_type drv; // Driver controls
  int mismatches = 0; // Failed comparisons
  int checks = 0; // All comparisons
  wave_shaping_timing_regs DUT (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .carrier_tick(carrier_tick), .mod_pulse(mod_pulse), .drv(drv));
  // Half period of 5 ns
  always #5 clk = ~clk;
  // ----------------------------------------
  // Comparison, bus and stimulus tasks
  // ----------------------------------------
  // Case equality so an unknown never matches
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Order is clamp_released, on_mod_rail, mod_resistance, driving
  task automatic cmp_drv(input logic [3:0] exp);
    cmp({4'h0, drv}, {4'h0, exp});
  endtask : cmp_drv
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask : rd
  // One carrier period, then let the control update settle
  task automatic tick();
    @(posedge clk);
    carrier_tick <= 1'b1;
    @(posedge clk);
    carrier_tick <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : tick
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values and read-back of the stored fields; the unmapped neighbours read zero
  task automatic t_regs();
    logic [7:0] addr[5] = '{`ADDR_CLAMP_RELEASE, `ADDR_MOD_SWITCH_RES, `ADDR_STOP_RAIL_RET,
      `ADDR_CLAMP_CONNECT, `ADDR_RES_RETURN};
    logic [7:0] mask[5] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'hf0};
    cmp_drv(4'h1);
    for (int i = 0; i < 5; i++) begin
      rd(addr[i], `REG_RESET);
      wr(addr[i], mask[i]);
      rd(addr[i], mask[i]);
    end
    // Last read returned a non-zero value, so stale data would show here
    @(posedge clk);
    #1 cmp(rdata, 8'h00);
    rd(8'h33, 8'h00);
    rd(8'h39, 8'h00);
  endtask : t_regs
  // A full pulse with staggered fields in both phases
  task automatic t_pulse();
    wr(`ADDR_CLAMP_RELEASE, 8'h02);
    wr(`ADDR_MOD_SWITCH_RES, 8'h01);
    wr(`ADDR_STOP_RAIL_RET, 8'h31);
    wr(`ADDR_CLAMP_CONNECT, 8'h02);
    wr(`ADDR_RES_RETURN, 8'h00);
    @(posedge clk);
    mod_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp_drv(4'b0101);
    tick();
    cmp_drv(4'b0111);
    tick();
    cmp_drv(4'b1111);
    tick();
    cmp_drv(4'b1110);
    @(posedge clk);
    mod_pulse <= 1'b0;
    repeat (4) @(posedge clk);
    #1 cmp_drv(4'b1101);
    tick();
    cmp_drv(4'b1001);
    tick();
    cmp_drv(4'b0001);
  endtask : t_pulse
  // A new pulse during recovery restarts the count; then recovery runs out
  task automatic t_restart();
    @(posedge clk);
    mod_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp_drv(4'b0101);
    tick();
    tick();
    cmp_drv(4'b1111);
    tick();
    cmp_drv(4'b1110);
    @(posedge clk);
    mod_pulse <= 1'b0;
    repeat (17) tick();
    cmp_drv(4'b0001);
  endtask : t_restart
  // A reset in mid-pulse clears the controls and the timing fields again
  task automatic t_rereset();
    @(posedge clk);
    mod_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp_drv(4'b0101);
    @(posedge clk);
    rst_b <= 1'b0;
    mod_pulse <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`ADDR_STOP_RAIL_RET, `REG_RESET);
    rd(`ADDR_MOD_SWITCH_RES, `REG_RESET);
    cmp_drv(4'h1);
  endtask : t_rereset
  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // The tests need well under a thousand cycles
  initial begin
    #50us;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pulse();
    t_restart();
    t_rereset();
    end_sim();
  end
endmodule : tb_wave_shaping_timing_regs
